// *** verilog/mbg_cfg.svh ***
`ifndef MBG_CFG_SVH
`define MBG_CFG_SVH

// ==================================================================
// register map (byte addresses, 32-bit words)
`define MBG_CTRL_ADDR     12'h000
`define MBG_STAT_ADDR     12'h004
`define MBG_SEND_ADDR     12'h008
`define MBG_FBO_BASE      12'h100
`define MBG_FBI_BASE      12'h200
`define MBG_CTRL_RESET    32'h0000_0000

// ==================================================================
// control word fields
`define MBG_C_MODE_LSB    0
`define MBG_C_TRIG        2
`define MBG_C_LEN         3
`define MBG_C_ONTRIG      4
`define MBG_C_RESP_LSB    8

// ==================================================================
// status word fields
`define MBG_S_TMO         0
`define MBG_S_CRC         1
`define MBG_S_BUSY        2
`define MBG_S_STN_LSB     8

// ==================================================================
// buffers
`define MBG_BUF_BYTES     64
`define MBG_BUF_AW        6
`define MBG_LANES         4

// ==================================================================
// timing
`define MBG_RESP_UNIT_MS  10
`define MBG_NS_PER_MS     1000000
`define MBG_CLK_NS        10

// ==================================================================
// frame layout
`define MBG_FC_RDCOIL     8'h01
`define MBG_FC_RDINP      8'h02
`define MBG_FC_RDHOLD     8'h03
`define MBG_FC_RDIREG     8'h04
`define MBG_FC_WRMCOIL    8'h0f
`define MBG_FC_WRMREG     8'h10
`define MBG_REQ_FIX_LEN   9'h006
`define MBG_REQ_MULTI_LEN 9'h007
`define MBG_REQ_BC_POS    6'h06
`define MBG_RX_MIN        7'h04
`define MBG_CRC_BYTES     7'h02
`define MBG_ADDR_CRC      7'h03
`define MBG_CRC_INIT      16'hffff
`define MBG_CRC_POLY      16'ha001
`define MBG_CRC_RESIDUE   16'h0000

`endif

// *** verilog/mbg_pkg.sv ***
package mbg_pkg;
  `include "mbg_cfg.svh"

  typedef enum logic [1:0] {
    MBG_MODE_MASTER,
    MBG_MODE_SLAVE,
    MBG_MODE_UNIV,
    MBG_MODE_RSVD
  } mbg_mode_t;

  typedef enum logic [1:0] {
    MBG_ST_IDLE,
    MBG_ST_TX,
    MBG_ST_WAIT,
    MBG_ST_ANS
  } mbg_state_t;

  typedef logic [`MBG_BUF_BYTES-1:0][7:0] mbg_buf_t;

  typedef struct packed {
    logic [15:0] crc;
  } mbg_crc_state_t;

  typedef struct packed {
    mbg_state_t       st;
    mbg_mode_t        mode;
    logic             trig_en;
    logic             len_en;
    logic             on_trig;
    logic [7:0]       resp;
    logic             tmo;
    logic             crc_bad;
    logic             send_pend;
    logic [7:0]       last_trig;
    logic [7:0]       stn;
    mbg_buf_t         fbo;
    mbg_buf_t         fbi;
    mbg_buf_t         rxb;
    logic [6:0]       rx_n;
    logic             got;
    logic [31:0]      tmr;
    logic [8:0]       tx_k;
    logic [8:0]       tx_len;
    logic [2:0][7:0]  pre;
    logic [1:0]       pre_n;
    logic [5:0]       base;
    logic             tx_v;
    logic [7:0]       tx_d;
    logic [31:0]      prdata;
    logic             perr;
  } mbg_fr_state_t;
endpackage

// *** verilog/mbg_crc_if.sv ***
`timescale 1ns/1ns
interface mbg_crc_if;
  logic        clr;
  logic        en;
  logic [7:0]  data;
  logic [15:0] crc;
  modport user (output clr, output en, output data, input crc);
  modport unit (input clr, input en, input data, output crc);
endinterface

// *** verilog/mbg_crc.sv ***
`timescale 1ns/1ns
`include "mbg_cfg.svh"
module mbg_crc
  import mbg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  mbg_crc_if.unit  crc_if
);

  mbg_crc_state_t c_q;
  mbg_crc_state_t c_d;
  logic [15:0]    x;

  // ================================================================
  // crc-16, reflected, low byte goes out first
  always_comb begin
    x = crc_if.clr ? `MBG_CRC_INIT : c_q.crc;
    c_d = c_q;
    if (crc_if.en) begin
      x = x ^ {8'h00, crc_if.data};
      for (int b = 0; b < 8; b++) begin
        x = x[0] ? ((x >> 1) ^ `MBG_CRC_POLY) : (x >> 1);
      end
    end
    c_d.crc = x;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // preset so a first inquiry after reset checks like any other
      c_q.crc <= `MBG_CRC_INIT;
    end else begin
      c_q <= c_d;
    end
  end

  assign crc_if.crc = c_q.crc;

  // ================================================================
  // checks
  property p_crc_clear;
    @(posedge pclk) disable iff (!presetn)
    crc_if.clr && !crc_if.en |=> crc_if.crc == `MBG_CRC_INIT;
  endproperty
  a_crc_clear: assert property (p_crc_clear)
    else $error("crc not reloaded after clear");

endmodule

// *** verilog/mbg_framer.sv ***
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "mbg_cfg.svh"
module mbg_framer
  import mbg_pkg::*;
#(
  parameter int unsigned RESP_UNIT_CYC =
    (`MBG_RESP_UNIT_MS * `MBG_NS_PER_MS) / `MBG_CLK_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  address_switch_high,
  input  wire logic [3:0]  address_switch_low,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_end,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,
  output logic             timeout_err
);

  mbg_fr_state_t s_q;
  mbg_fr_state_t s_d;
  mbg_crc_if     crc_if ();

  logic [5:0]  hdr;
  logic [5:0]  len_idx;
  logic [5:0]  b0;
  logic [7:0]  fb_len;
  logic [7:0]  tx_byte;
  logic [8:0]  auto_len;
  logic        trig_chg;
  logic        apb_setup;
  logic        apb_wr;
  logic        in_fbo;
  logic        in_fbi;
  logic        univ_len;
  logic        collecting;
  logic        frame_end;
  logic        crc_ok;
  logic        accept;
  logic [31:0] limit;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic [15:0] coil_sum;
  logic        do_fbi;
  logic [6:0]  fskip;
  logic [6:0]  fcnt;
  logic [5:0]  bi;
  int          j;

  mbg_crc u_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .crc_if  (crc_if.unit)
  );

  // ================================================================
  // decode and derived values
  assign hdr       = {5'h00, s_q.trig_en} + {5'h00, s_q.len_en};
  assign len_idx   = {5'h00, s_q.trig_en};
  assign fb_len    = s_q.fbo[len_idx];
  assign trig_chg  = s_q.trig_en && (s_q.fbo[0] != s_q.last_trig);
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign in_fbo    = (paddr >= `MBG_FBO_BASE) &&
                     (paddr < `MBG_FBO_BASE + 12'(`MBG_BUF_BYTES));
  assign in_fbi    = (paddr >= `MBG_FBI_BASE) &&
                     (paddr < `MBG_FBI_BASE + 12'(`MBG_BUF_BYTES));
  assign univ_len  = s_q.mode == MBG_MODE_UNIV && s_q.len_en;
  assign b0        = {paddr[`MBG_BUF_AW-1:2], 2'b00};
  assign limit     = 32'(s_q.resp) * 32'(RESP_UNIT_CYC);
  assign coil_sum  = {s_q.rxb[4], s_q.rxb[5]} + 16'h0007;
  assign collecting = (s_q.st == MBG_ST_IDLE &&
                       s_q.mode != MBG_MODE_MASTER) ||
                      s_q.st == MBG_ST_WAIT;
  assign frame_end = rx_end && collecting;
  assign crc_ok    = crc_if.crc == `MBG_CRC_RESIDUE &&
                     s_q.rx_n >= `MBG_RX_MIN;
  assign accept    = frame_end && crc_ok &&
                     (s_q.mode == MBG_MODE_MASTER ||
                      s_q.rxb[0] == s_q.stn);

  // request length from function code when no length byte is used
  always_comb begin
    if (s_q.fbo[hdr + 6'h01] == `MBG_FC_WRMCOIL ||
        s_q.fbo[hdr + 6'h01] == `MBG_FC_WRMREG) begin
      auto_len = `MBG_REQ_MULTI_LEN +
                 {1'b0, s_q.fbo[hdr + `MBG_REQ_BC_POS]};
    end else begin
      auto_len = `MBG_REQ_FIX_LEN;
    end
  end

  always_comb begin
    ctrl_word = `MBG_CTRL_RESET;
    ctrl_word[`MBG_C_MODE_LSB +: 2] = s_q.mode;
    ctrl_word[`MBG_C_TRIG]          = s_q.trig_en;
    ctrl_word[`MBG_C_LEN]           = s_q.len_en;
    ctrl_word[`MBG_C_ONTRIG]        = s_q.on_trig;
    ctrl_word[`MBG_C_RESP_LSB +: 8] = s_q.resp;
    stat_word = 32'h0;
    stat_word[`MBG_S_TMO]           = s_q.tmo;
    stat_word[`MBG_S_CRC]           = s_q.crc_bad;
    stat_word[`MBG_S_BUSY]          = s_q.st != MBG_ST_IDLE;
    stat_word[`MBG_S_STN_LSB +: 8]  = s_q.stn;
  end

  // ================================================================
  // outgoing byte: prefix bytes, buffer bytes, then crc low/high
  always_comb begin
    if (s_q.tx_k < s_q.tx_len) begin
      if (s_q.tx_k < {7'h00, s_q.pre_n}) begin
        tx_byte = s_q.pre[s_q.tx_k[1:0]];
      end else begin
        tx_byte = s_q.fbo[s_q.base + s_q.tx_k[5:0] -
                          {4'h0, s_q.pre_n}];
      end
    end else if (s_q.tx_k == s_q.tx_len) begin
      tx_byte = crc_if.crc[7:0];
    end else begin
      tx_byte = crc_if.crc[15:8];
    end
  end

  // ================================================================
  // next state
  always_comb begin
    s_d = s_q;
    do_fbi = 1'b0;
    fskip = 7'h00;
    fcnt = 7'h00;
    bi = 6'h00;
    j = 0;
    crc_if.clr = 1'b0;
    crc_if.en = 1'b0;
    crc_if.data = rx_data;
    s_d.stn = {address_switch_high, address_switch_low};

    // read data is captured in the setup cycle: zero wait states
    if (apb_setup) begin
      s_d.perr = 1'b0;
      s_d.prdata = 32'h0;
      if (paddr == `MBG_CTRL_ADDR) begin
        s_d.prdata = ctrl_word;
      end else if (paddr == `MBG_STAT_ADDR) begin
        s_d.prdata = stat_word;
      end else if (in_fbo) begin
        s_d.prdata = s_q.fbo[b0 +: `MBG_LANES];
      end else if (in_fbi) begin
        s_d.prdata = s_q.fbi[b0 +: `MBG_LANES];
      end else if (paddr != `MBG_SEND_ADDR) begin
        s_d.perr = 1'b1;
      end
    end

    // mode changes act at once; software changes them while idle
    if (apb_wr) begin
      if (paddr == `MBG_CTRL_ADDR) begin
        s_d.mode    = mbg_mode_t'(pwdata[`MBG_C_MODE_LSB +: 2]);
        s_d.trig_en = pwdata[`MBG_C_TRIG];
        s_d.len_en  = pwdata[`MBG_C_LEN];
        s_d.on_trig = pwdata[`MBG_C_ONTRIG];
        s_d.resp    = pwdata[`MBG_C_RESP_LSB +: 8];
      end else if (paddr == `MBG_STAT_ADDR) begin
        s_d.tmo     = s_q.tmo & ~pwdata[`MBG_S_TMO];
        s_d.crc_bad = s_q.crc_bad & ~pwdata[`MBG_S_CRC];
      end else if (paddr == `MBG_SEND_ADDR) begin
        s_d.send_pend = 1'b1;
      end else if (in_fbo) begin
        for (int l = 0; l < `MBG_LANES; l++) begin
          bi = b0 + 6'(l);
          // a length byte in the same word governs its own data lanes
          if (pstrb[l] && !(univ_len && bi >= hdr &&
              {2'b00, bi - hdr} >= s_d.fbo[len_idx])) begin
            s_d.fbo[bi] = pwdata[8*l +: 8];
          end
        end
      end
    end

    // receive path; bytes past the buffer end are dropped
    if (collecting && rx_valid) begin
      crc_if.en = 1'b1;
      if (s_q.rx_n < 7'(`MBG_BUF_BYTES)) begin
        s_d.rxb[s_q.rx_n[5:0]] = rx_data;
        s_d.rx_n = s_q.rx_n + 7'h01;
      end
    end

    case (s_q.st)
      MBG_ST_IDLE: begin
        if (s_q.mode == MBG_MODE_MASTER) begin
          if (s_q.on_trig ? trig_chg : s_q.send_pend) begin
            s_d.send_pend = apb_wr && paddr == `MBG_SEND_ADDR;
            s_d.last_trig = s_q.fbo[0];
            s_d.tx_len = s_q.len_en ? {1'b0, fb_len} : auto_len;
            s_d.pre_n = 2'h0;
            s_d.base = hdr;
            s_d.tx_k = 9'h000;
            crc_if.clr = 1'b1;
            s_d.st = MBG_ST_TX;
          end
        end
      end
      MBG_ST_TX: begin
        if (!s_q.tx_v || tx_ready) begin
          if (s_q.tx_k < s_q.tx_len + 9'h002) begin
            s_d.tx_v = 1'b1;
            s_d.tx_d = tx_byte;
            s_d.tx_k = s_q.tx_k + 9'h001;
            if (s_q.tx_k < s_q.tx_len) begin
              crc_if.en = 1'b1;
              crc_if.data = tx_byte;
            end
          end else begin
            s_d.tx_v = 1'b0;
            crc_if.clr = 1'b1;
            s_d.rx_n = 7'h00;
            s_d.tmr = 32'h0;
            s_d.got = 1'b0;
            s_d.st = (s_q.mode == MBG_MODE_MASTER) ? MBG_ST_WAIT
                                                   : MBG_ST_IDLE;
          end
        end
      end
      MBG_ST_WAIT: begin
        if (rx_valid) begin
          s_d.got = 1'b1;
        end else if (!s_q.got) begin
          s_d.tmr = s_q.tmr + 32'h1;
          if (s_q.tmr >= limit) begin
            s_d.tmo = 1'b1;
            s_d.st = MBG_ST_IDLE;
          end
        end
      end
      MBG_ST_ANS: begin
        if (s_q.trig_en ? trig_chg : s_q.send_pend) begin
          s_d.send_pend = apb_wr && paddr == `MBG_SEND_ADDR;
          s_d.last_trig = s_q.fbo[0];
          s_d.pre[0] = s_q.stn;
          s_d.pre_n = 2'h1;
          s_d.base = hdr;
          s_d.tx_len = 9'h001 + (s_q.len_en ? {1'b0, fb_len} :
                       9'(`MBG_BUF_BYTES) - {3'h0, hdr});
          s_d.tx_k = 9'h000;
          crc_if.clr = 1'b1;
          s_d.st = MBG_ST_TX;
        end
      end
      default: begin
        s_d.st = MBG_ST_IDLE;
      end
    endcase

    // a frame with a bad check, or outside master mode a foreign address, leaves the image untouched; a bad check sets crc_bad
    if (frame_end) begin
      crc_if.clr = 1'b1;
      s_d.rx_n = 7'h00;
      s_d.got = 1'b0;
      if (!crc_ok) begin
        s_d.crc_bad = 1'b1;
      end
      if (accept) begin
        case (s_q.mode)
          MBG_MODE_MASTER: begin
            do_fbi = 1'b1;
            fcnt = s_q.rx_n - `MBG_CRC_BYTES;
            s_d.st = MBG_ST_IDLE;
          end
          MBG_MODE_SLAVE: begin
            do_fbi = 1'b1;
            fskip = 7'h01;
            fcnt = s_q.rx_n - `MBG_ADDR_CRC;
            s_d.st = MBG_ST_ANS;
          end
          default: begin
            s_d.pre[0] = s_q.stn;
            s_d.pre[1] = s_q.rxb[1];
            s_d.pre_n = 2'h3;
            s_d.tx_k = 9'h000;
            if (s_q.rxb[1] == `MBG_FC_RDCOIL ||
                s_q.rxb[1] == `MBG_FC_RDINP) begin
              // whole bytes only: start snaps down to its 8-coil group
              s_d.pre[2] = coil_sum[10:3];
              s_d.base = hdr + {s_q.rxb[2][0], s_q.rxb[3][7:3]};
              s_d.st = MBG_ST_TX;
            end else if (s_q.rxb[1] == `MBG_FC_RDHOLD ||
                         s_q.rxb[1] == `MBG_FC_RDIREG) begin
              s_d.pre[2] = {s_q.rxb[5][6:0], 1'b0};
              s_d.base = hdr + {s_q.rxb[3][4:0], 1'b0};
              s_d.st = MBG_ST_TX;
            end
            s_d.tx_len = 9'h003 + {1'b0, s_d.pre[2]};
          end
        endcase
      end
    end

    // fieldbus image: trigger, length, data, zero padded
    if (do_fbi) begin
      for (int i = 0; i < `MBG_BUF_BYTES; i++) begin
        j = i - int'(hdr) + int'(fskip);
        if (i >= int'(hdr)) begin
          s_d.fbi[i] = 8'h00;
          if (i - int'(hdr) < int'(fcnt) && j < `MBG_BUF_BYTES) begin
            s_d.fbi[i] = s_q.rxb[j[5:0]];
          end
        end
      end
      if (s_q.trig_en) begin
        s_d.fbi[0] = s_q.fbi[0] + 8'h01;
      end
      if (s_q.len_en) begin
        s_d.fbi[len_idx] = {1'b0, fcnt};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata      = s_q.prdata;
  assign pready      = 1'b1;
  assign pslverr     = s_q.perr;
  assign tx_valid    = s_q.tx_v;
  assign tx_data     = s_q.tx_d;
  assign timeout_err = s_q.tmo;

  // ================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_trig_change;
    s_q.st == MBG_ST_IDLE && s_q.mode == MBG_MODE_MASTER &&
    s_q.on_trig && trig_chg;
  endsequence
  sequence s_tx_start;
    s_q.st == MBG_ST_TX && s_q.tx_k == 9'h000 &&
    s_q.last_trig == $past(s_q.fbo[0]);
  endsequence

  property p_trig_start;
    s_trig_change |=> s_tx_start;
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger change did not start a request");

  property p_trig_hold;
    s_q.st == MBG_ST_IDLE && s_q.mode == MBG_MODE_MASTER &&
    s_q.on_trig && !trig_chg |=> s_q.st == MBG_ST_IDLE;
  endproperty
  a_trig_hold: assert property (p_trig_hold)
    else $error("request sent without trigger change");

  property p_tmo_time;
    $rose(s_q.tmo) |-> $past(s_q.tmr) == $past(limit) &&
                       $past(s_q.st) == MBG_ST_WAIT;
  endproperty
  a_tmo_time: assert property (p_tmo_time)
    else $error("timeout not at configured response time");

  property p_tmo_set;
    s_q.st == MBG_ST_WAIT && !s_q.got && !rx_valid &&
    s_q.tmr >= limit |=> s_q.tmo && s_q.st == MBG_ST_IDLE;
  endproperty
  a_tmo_set: assert property (p_tmo_set)
    else $error("missing response not flagged");

  property p_m_trig;
    accept && s_q.mode == MBG_MODE_MASTER && s_q.trig_en
    |=> s_q.fbi[0] == $past(s_q.fbi[0]) + 8'h01;
  endproperty
  a_m_trig: assert property (p_m_trig)
    else $error("trigger not incremented on response");

  property p_s_len;
    accept && s_q.mode == MBG_MODE_SLAVE && s_q.len_en
    |=> s_q.fbi[$past(len_idx)] == 8'($past(s_q.rx_n) - 7'h03) &&
        s_q.st == MBG_ST_ANS;
  endproperty
  a_s_len: assert property (p_s_len)
    else $error("slave length byte wrong");

  property p_addr;
    frame_end && crc_ok && s_q.mode != MBG_MODE_MASTER &&
    s_q.rxb[0] != s_q.stn |=> $stable(s_q.fbi) && s_q.st == MBG_ST_IDLE;
  endproperty
  a_addr: assert property (p_addr)
    else $error("foreign inquiry accepted");

  property p_crc_drop;
    frame_end && !crc_ok |=> $stable(s_q.fbi) && s_q.st != MBG_ST_TX;
  endproperty
  a_crc_drop: assert property (p_crc_drop)
    else $error("bad frame was forwarded");

  property p_len_mask;
    apb_wr && in_fbo && univ_len && pstrb[0] && b0 >= hdr &&
    {2'b00, b0 - hdr} >= fb_len
    |=> s_q.fbo[$past(b0)] == $past(s_q.fbo[b0]);
  endproperty
  a_len_mask: assert property (p_len_mask)
    else $error("byte beyond length overwritten");

endmodule

// *** verification/mbg_peer.sv ***
`timescale 1ns/1ns
module mbg_peer (
  input  wire logic       pclk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_end
);
  // ==================================================================
  // serial far end: collects sent bytes, plays back frames
  logic [7:0] got[$];
  logic       slow;
  initial begin
    got = {};
    slow = 1'b0;
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
  end
  // slow mode stalls every other cycle to stress the hold of tx_data
  always @(posedge pclk) begin
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // frame end is a separate pulse, one cycle after the last byte
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= f[i];
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    @(posedge pclk);
    rx_end <= 1'b0;
  endtask
endmodule

// *** verification/mbg_framer_tb.sv ***
`timescale 1ns/1ns
module mbg_framer_tb;
  typedef logic [7:0] mbg_bq_t[$];
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  sw_hi;
  logic [3:0]  sw_lo;
  logic        rxv;
  logic [7:0]  rxd;
  logic        rxe;
  logic        txv;
  logic [7:0]  txd;
  logic        txr;
  logic        tmo;
  logic [31:0] rdat;
  logic        rerr;
  logic [7:0]  t;
  int          n;
  int          miscompares;
  int          total_checks;

  mbg_framer #(.RESP_UNIT_CYC(10)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .address_switch_high(sw_hi), .address_switch_low(sw_lo),
    .rx_valid(rxv), .rx_data(rxd), .rx_end(rxe), .tx_valid(txv),
    .tx_data(txd), .tx_ready(txr), .timeout_err(tmo));
  mbg_peer peer_u (
    .pclk(pclk), .tx_valid(txv), .tx_data(txd), .tx_ready(txr),
    .rx_valid(rxv), .rx_data(rxd), .rx_end(rxe));

  always #5 pclk = ~pclk;

  // ==================================================================
  // helpers
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("[ERR] pready expected 1 seen %b", pready);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat & m);
  endtask

  function automatic mbg_bq_t addc(input mbg_bq_t f);
    logic [15:0] c;
    c = 16'hffff;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    return f;
  endfunction

  // word 0 goes last so a trigger change sees the data already in place
  task automatic put_fbo(input mbg_bq_t b);
    logic [31:0] w;
    for (int i = (b.size() - 1) / 4 * 4; i >= 0; i -= 4) begin
      w = 32'h0;
      for (int k = 0; k < 4; k++)
        if (i + k < b.size())
          w[8*k+:8] = b[i+k];
      apb(1'b1, 12'h100 + 12'(i), w);
    end
  endtask

  task automatic txc(input mbg_bq_t e);
    int k;
    k = 0;
    e = addc(e);
    while (peer_u.got.size() < e.size() && k < 500) begin
      @(posedge pclk);
      k++;
    end
    repeat (2) @(posedge pclk);
    chk("tx count", 32'(e.size()), 32'(peer_u.got.size()));
    foreach (e[i])
      if (i < peer_u.got.size())
        chk("tx byte", {24'h0, e[i]}, {24'h0, peer_u.got[i]});
    peer_u.got = {};
  endtask

  // ==================================================================
  // tests
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sw_hi = 4'h1;
    sw_lo = 4'h2;
    miscompares = 0;
    total_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", 12'h000, 32'hffffffff, 32'h0);
    rdc("station", 12'h004, 32'h0000ff00, 32'h00001200);
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, rerr});
    apb(1'b1, 12'h000, 32'h0000021c);
    put_fbo({8'h05, 8'h06, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02, 8'hee});
    txc({8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02});
    peer_u.send(addc({8'h01, 8'h03, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44}));
    rdc("fbi w0", 12'h200, 32'hffffffff, 32'h03010701);
    rdc("fbi w1", 12'h204, 32'hffffffff, 32'h33221104);
    apb(1'b1, 12'h100, 32'h03010606);
    txc({8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02});
    n = 0;
    while (tmo !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("timeout", 32'h1, {31'h0, tmo});
    rdc("tmo stat", 12'h004, 32'h1, 32'h1);
    apb(1'b1, 12'h004, 32'h1);
    rdc("tmo clr", 12'h004, 32'h1, 32'h0);
    // longer response time so the bad frame cannot run into the limit
    apb(1'b1, 12'h000, 32'h00000800);
    peer_u.slow <= 1'b1;
    put_fbo({8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02, 8'hee, 8'hee});
    apb(1'b1, 12'h008, 32'h1);
    txc({8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02});
    peer_u.slow <= 1'b0;
    peer_u.send({8'h01, 8'h03, 8'h02, 8'haa, 8'hbb, 8'h00, 8'h00});
    rdc("bad crc", 12'h200, 32'hffffffff, 32'h03010701);
    rdc("crc flag", 12'h004, 32'h2, 32'h2);
    peer_u.send(addc({8'h01, 8'h03, 8'h02, 8'haa, 8'hbb}));
    rdc("fbi raw", 12'h200, 32'hffffffff, 32'haa020301);
    apb(1'b1, 12'h000, 32'h0000000d);
    apb(1'b0, 12'h200, 32'h0);
    t = rdat[7:0];
    peer_u.send(addc({8'h13, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}));
    rdc("other id", 12'h200, 32'h000000ff, {24'h0, t});
    peer_u.send(addc({8'h12, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}));
    rdc("inq w0", 12'h200, 32'hffffffff, {16'h0003, 8'h05, t + 8'h01});
    rdc("inq w1", 12'h204, 32'h00ffffff, 32'h00010000);
    put_fbo({8'h40, 8'h03, 8'h03, 8'h02, 8'hab, 8'hcd});
    txc({8'h12, 8'h03, 8'h02, 8'hab});
    apb(1'b1, 12'h000, 32'h0000000a);
    put_fbo({8'h02, 8'ha5, 8'h3c, 8'h77});
    peer_u.send(addc({8'h12, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}));
    txc({8'h12, 8'h03, 8'h04, 8'ha5, 8'h3c, 8'h02, 8'hab});
    peer_u.send(addc({8'h12, 8'h01, 8'h00, 8'h0a, 8'h00, 8'h08}));
    txc({8'h12, 8'h01, 8'h01, 8'h3c});
    apb(1'b1, 12'h104, 32'h11223344);
    rdc("len mask", 12'h104, 32'hffffffff, 32'h0000cdab);
    wrap_up();
  end

  // whole run is a few hundred cycles; ten thousand means a hang
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule
